// ===== accel_regs_pkg.sv
// Register map, field layout and shared types of the accel register bank
package accel_regs_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_OUT_CTRL = 6'h23;
	localparam logic [5:0] IDX_WAKE_CTRL = 6'h24;
	localparam logic [5:0] IDX_FILT_ZERO = 6'h25;
	localparam logic [5:0] IDX_FILT_REF = 6'h26;
	localparam logic [5:0] IDX_STATUS = 6'h27;
	localparam logic [5:0] IDX_X_LOW = 6'h28;
	localparam logic [5:0] IDX_X_HIGH = 6'h29;
	localparam logic [5:0] IDX_Y_LOW = 6'h2A;
	localparam logic [5:0] IDX_Y_HIGH = 6'h2B;
	localparam logic [5:0] IDX_Z_LOW = 6'h2C;
	localparam logic [5:0] IDX_Z_HIGH = 6'h2D;
	localparam logic [5:0] IDX_EV1_CFG = 6'h30;
	localparam logic [5:0] IDX_EV1_SRC = 6'h31;
	localparam logic [5:0] IDX_FILT_CTRL = 6'h38;
	localparam logic [5:0] IDX_EV1_SETUP = 6'h39;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OC_LOCK = 7;
	localparam int OC_ORDER = 6;
	localparam int OC_RANGE_HI = 5;
	localparam int OC_RANGE_LO = 4;
	localparam int OC_POLARITY = 3;
	localparam int OC_CHECK = 1;
	localparam int OC_WIRE = 0;
	localparam logic [7:0] OC_WMASK = 8'hFB;
	localparam logic [7:0] WAKE_WMASK = 8'h03;
	localparam int FC_MODE_HI = 6;
	localparam int FC_MODE_LO = 5;
	localparam int FC_FDS = 3;
	localparam int FC_HIPASS_EVENT2_ENABLE = 2;
	localparam int FC_HIPASS_EVENT1_ENABLE = 1;
	localparam logic [7:0] FC_WMASK = 8'h6E;
	localparam int ES_LATCH = 7;
	localparam int CFG_COMBINE = 7;
	localparam int CFG_SIX_DIR = 6;

	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] WAKE_ON = 2'h3;
	localparam logic [1:0] WAKE_OFF = 2'h0;
	localparam logic [1:0] HP_REFERENCE = 2'h1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int HP_SHIFT = 3;

	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} sample_s;

endpackage : accel_regs_pkg

// ===== axis_channel.sv
// One axis output pair: update lock, pending sample, new and overrun flags
`timescale 1ns/1ps
module axis_channel
	import accel_regs_pkg::*;
#(
	parameter int W = 16
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample side
	input wire logic strobe,
	input wire logic [W-1:0] value,
	input wire logic lock_en,
	// Host reads of the pair
	input wire logic read_low,
	input wire logic read_high,
	// State
	output logic [W-1:0] out_q,
	output logic new_q,
	output logic overrun_q
);
	logic rd_lo_q;
	logic rd_hi_q;
	logic pend_q;
	logic [W-1:0] pend_val_q;
	logic frozen;
	logic done;

	assign frozen = lock_en && (rd_lo_q || rd_hi_q);
	assign done = (rd_lo_q || read_low) && (rd_hi_q || read_high);

	// Pair read tracking, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn || done)
		begin
			rd_lo_q <= 1'b0;
			rd_hi_q <= 1'b0;
		end
		else
		begin
			rd_lo_q <= rd_lo_q || read_low;
			rd_hi_q <= rd_hi_q || read_high;
		end
	end

	// Freeze between the two byte reads
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_q <= '0;
			pend_q <= 1'b0;
			pend_val_q <= '0;
		end
		else if (strobe && frozen && !done)
		begin
			pend_q <= 1'b1;
			pend_val_q <= value;
		end
		else if (strobe)
		begin
			out_q <= value;
			pend_q <= 1'b0;
		end
		else if (done && pend_q)
		begin
			out_q <= pend_val_q;
			pend_q <= 1'b0;
		end
	end

	// Set wins over the read clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			new_q <= 1'b0;
			overrun_q <= 1'b0;
		end
		else if (strobe)
		begin
			new_q <= 1'b1;
			overrun_q <= overrun_q || (new_q && !done);
		end
		else if (done)
		begin
			new_q <= 1'b0;
			overrun_q <= 1'b0;
		end
	end

endmodule : axis_channel

// ===== event1_logic.sv
// Event 1 detection: per-axis threshold compare, combine modes, latching
`timescale 1ns/1ps
module event1_logic
	import accel_regs_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample and setup
	input wire logic strobe,
	input wire sample_s smp,
	input wire logic [6:0] threshold,
	input wire logic [7:0] cfg,
	input wire logic latch_en,
	input wire logic src_read,
	// Result
	output logic [6:0] src_q,
	output logic hit
);
	logic signed [7:0] hi [3];
	logic signed [8:0] thr;
	logic [5:0] ev;
	logic [5:0] en;
	logic [5:0] pos_q;
	logic [5:0] pos_new;
	logic act;

	assign hi[0] = smp.x[15:8];
	assign hi[1] = smp.y[15:8];
	assign hi[2] = smp.z[15:8];
	assign thr = {2'b00, threshold};
	assign en = cfg[5:0];

	// Order per axis: below, above
	for (genvar a = 0; a < 3; a++)
	begin : g_cmp
		assign ev[2*a+1] = hi[a] > thr;
		assign ev[2*a] = hi[a] < -thr;
	end

	assign pos_new = ev & en;

	always_comb
	begin
		unique case ({cfg[CFG_COMBINE], cfg[CFG_SIX_DIR]})
			2'b00: act = |pos_new;
			2'b01: act = |pos_new && (pos_new != pos_q);
			2'b10: act = (|en) && (&(ev | ~en));
			2'b11: act = |pos_new;
		endcase
	end

	assign hit = strobe && act;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pos_q <= '0;
		else if (strobe)
			pos_q <= pos_new;
	end

	// Latched contents refresh only while bit 6 is clear or in the cycle of a source read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			src_q <= '0;
		else if (strobe && (!latch_en || !src_q[6] || src_read))
			src_q <= {act, pos_new};
		else if (src_read)
			src_q[6] <= 1'b0;
	end

endmodule : event1_logic

// ===== accel_regs.sv
// Accel output, wake, filter, status, data and event 1 register bank
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module accel_regs
	import accel_regs_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W/8-1:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// Sensor core samples
	input wire logic sample_strobe,
	input wire sample_s sample_raw,
	// Controls toward the sensor core
	output logic [1:0] range_select,
	output logic check_polarity,
	output logic check_drive_enable,
	output logic wire_mode_select,
	output logic wake_normal,
	output logic event1_pin
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] out_ctrl_q;
	logic [7:0] wake_ctrl_q;
	logic [7:0] ref_q;
	logic [7:0] ev1_cfg_q;
	logic [7:0] filt_ctrl_q;
	logic [7:0] ev1_setup_q;
	logic wake_normal_q;
	logic event1_pin_q;

	// AXI state
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic aw_held_q;
	logic w_held_q;
	logic [5:0] wr_idx_q;
	logic [7:0] wr_byte_q;
	logic wr_en_q;

	// Filter state
	logic signed [15:0] base_q [3];
	logic signed [15:0] last_q [3];
	logic signed [15:0] raw [3];
	logic signed [15:0] filt [3];
	logic signed [15:0] diff [3];
	logic signed [15:0] refv;
	logic filter_on;
	logic ref_mode;

	// Channel results
	logic [15:0] ch_out [3];
	logic [2:0] ch_new;
	logic [2:0] ch_ovr;
	logic [2:0] rd_low;
	logic [2:0] rd_high;
	sample_s out_sel;
	sample_s ev_sel;
	logic [6:0] ev1_src;
	logic ev1_hit;

	// Read decode and write go
	logic rd_fire;
	logic [5:0] rd_idx;
	logic wr_go;
	logic [7:0] rd_byte;
	logic rd_ok;

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign range_select = out_ctrl_q[OC_RANGE_HI:OC_RANGE_LO];
	assign check_polarity = out_ctrl_q[OC_POLARITY];
	assign check_drive_enable = out_ctrl_q[OC_CHECK];
	assign wire_mode_select = out_ctrl_q[OC_WIRE];
	assign wake_normal = wake_normal_q;
	assign event1_pin = event1_pin_q;

	// ----------------------------------------------------------------
	// AXI write channel
	// ----------------------------------------------------------------
	assign wr_go = aw_held_q && w_held_q && !bvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			wr_idx_q <= '0;
			wr_byte_q <= '0;
			wr_en_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				awready_q <= 1'b0;
				aw_held_q <= 1'b1;
				wr_idx_q <= awaddr[7:2];
			end
			if (wvalid && wready_q)
			begin
				wready_q <= 1'b0;
				w_held_q <= 1'b1;
				wr_byte_q <= wdata[7:0];
				wr_en_q <= wstrb[0];
			end
			if (wr_go)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_known(wr_idx_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && bready)
			begin
				bvalid_q <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	function automatic logic wr_known(input logic [5:0] idx);
		return idx == IDX_OUT_CTRL || idx == IDX_WAKE_CTRL ||
			idx == IDX_FILT_REF || idx == IDX_EV1_CFG ||
			idx == IDX_FILT_CTRL || idx == IDX_EV1_SETUP;
	endfunction : wr_known

	// Writable registers; low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_ctrl_q <= REG_RESET;
			wake_ctrl_q <= REG_RESET;
			ref_q <= REG_RESET;
			ev1_cfg_q <= REG_RESET;
			filt_ctrl_q <= REG_RESET;
			ev1_setup_q <= REG_RESET;
		end
		else if (wr_go && wr_en_q)
		begin
			unique case (wr_idx_q)
				IDX_OUT_CTRL: out_ctrl_q <= wr_byte_q & OC_WMASK;
				IDX_WAKE_CTRL: wake_ctrl_q <= wr_byte_q & WAKE_WMASK;
				IDX_FILT_REF: ref_q <= wr_byte_q;
				IDX_EV1_CFG: ev1_cfg_q <= wr_byte_q;
				IDX_FILT_CTRL: filt_ctrl_q <= wr_byte_q & FC_WMASK;
				IDX_EV1_SETUP: ev1_setup_q <= wr_byte_q;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI read channel
	// ----------------------------------------------------------------
	assign rd_fire = arvalid && arready_q;
	assign rd_idx = araddr[7:2];

	always_comb
	begin
		rd_byte = 8'h00;
		rd_ok = 1'b1;
		unique case (rd_idx)
			IDX_OUT_CTRL: rd_byte = out_ctrl_q;
			IDX_WAKE_CTRL: rd_byte = wake_ctrl_q;
			IDX_FILT_ZERO: rd_byte = 8'h00;
			IDX_FILT_REF: rd_byte = ref_q;
			IDX_STATUS: rd_byte = {|ch_ovr, ch_ovr[2], ch_ovr[1],
				ch_ovr[0], &ch_new, ch_new};
			IDX_X_LOW: rd_byte = lane(ch_out[0], 1'b0);
			IDX_X_HIGH: rd_byte = lane(ch_out[0], 1'b1);
			IDX_Y_LOW: rd_byte = lane(ch_out[1], 1'b0);
			IDX_Y_HIGH: rd_byte = lane(ch_out[1], 1'b1);
			IDX_Z_LOW: rd_byte = lane(ch_out[2], 1'b0);
			IDX_Z_HIGH: rd_byte = lane(ch_out[2], 1'b1);
			IDX_EV1_CFG: rd_byte = ev1_cfg_q;
			IDX_EV1_SRC: rd_byte = {1'b0, ev1_src};
			IDX_FILT_CTRL: rd_byte = filt_ctrl_q;
			IDX_EV1_SETUP: rd_byte = ev1_setup_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// Upper address of a pair gives the high byte, or the low byte with the order bit set
	function automatic logic [7:0] lane(input logic [15:0] v,
		input logic upper);
		logic sel_high;
		sel_high = upper ^ out_ctrl_q[OC_ORDER];
		return sel_high ? v[15:8] : v[7:0];
	endfunction : lane

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {{(DATA_W-8){1'b0}}, rd_byte};
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_q && rready)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Byte reads steer the pair logic through the order bit
	for (genvar a = 0; a < 3; a++)
	begin : g_rd
		logic lo_at;
		logic hi_at;
		assign lo_at = rd_fire && rd_idx == IDX_X_LOW + 6'(2*a);
		assign hi_at = rd_fire && rd_idx == IDX_X_HIGH + 6'(2*a);
		assign rd_low[a] = out_ctrl_q[OC_ORDER] ? hi_at : lo_at;
		assign rd_high[a] = out_ctrl_q[OC_ORDER] ? lo_at : hi_at;
	end

	// ----------------------------------------------------------------
	// High-pass filter
	// ----------------------------------------------------------------
	assign raw[0] = sample_raw.x;
	assign raw[1] = sample_raw.y;
	assign raw[2] = sample_raw.z;
	assign refv = {ref_q, 8'h00};
	assign filter_on = filt_ctrl_q[FC_FDS] || filt_ctrl_q[FC_HIPASS_EVENT2_ENABLE] ||
		filt_ctrl_q[FC_HIPASS_EVENT1_ENABLE];
	assign ref_mode = filter_on &&
		filt_ctrl_q[FC_MODE_HI:FC_MODE_LO] == HP_REFERENCE;

	for (genvar a = 0; a < 3; a++)
	begin : g_hp
		assign diff[a] = raw[a] - base_q[a];
		assign filt[a] = ref_mode ? raw[a] - refv : diff[a];

		// Zeroing sets the baseline to the newest sample: output 0 g
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				base_q[a] <= '0;
				last_q[a] <= '0;
			end
			else if (rd_fire && rd_idx == IDX_FILT_ZERO)
			begin
				base_q[a] <= sample_strobe ? raw[a] : last_q[a];
				if (sample_strobe)
					last_q[a] <= raw[a];
			end
			else if (sample_strobe)
			begin
				base_q[a] <= base_q[a] + (diff[a] >>> HP_SHIFT);
				last_q[a] <= raw[a];
			end
		end
	end

	assign out_sel = filt_ctrl_q[FC_FDS] ?
		{filt[2], filt[1], filt[0]} : sample_raw;
	assign ev_sel = filt_ctrl_q[FC_HIPASS_EVENT1_ENABLE] ?
		{filt[2], filt[1], filt[0]} : sample_raw;

	// ----------------------------------------------------------------
	// Output pairs
	// ----------------------------------------------------------------
	axis_channel #(.W(16)) u_x (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(sample_strobe),
		.value(out_sel.x),
		.lock_en(out_ctrl_q[OC_LOCK]),
		.read_low(rd_low[0]),
		.read_high(rd_high[0]),
		.out_q(ch_out[0]),
		.new_q(ch_new[0]),
		.overrun_q(ch_ovr[0])
	);

	axis_channel #(.W(16)) u_y (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(sample_strobe),
		.value(out_sel.y),
		.lock_en(out_ctrl_q[OC_LOCK]),
		.read_low(rd_low[1]),
		.read_high(rd_high[1]),
		.out_q(ch_out[1]),
		.new_q(ch_new[1]),
		.overrun_q(ch_ovr[1])
	);

	axis_channel #(.W(16)) u_z (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(sample_strobe),
		.value(out_sel.z),
		.lock_en(out_ctrl_q[OC_LOCK]),
		.read_low(rd_low[2]),
		.read_high(rd_high[2]),
		.out_q(ch_out[2]),
		.new_q(ch_new[2]),
		.overrun_q(ch_ovr[2])
	);

	// ----------------------------------------------------------------
	// Event 1 and sleep-to-wake
	// ----------------------------------------------------------------
	event1_logic u_ev1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(sample_strobe),
		.smp(ev_sel),
		.threshold(ev1_setup_q[6:0]),
		.cfg(ev1_cfg_q),
		.latch_en(ev1_setup_q[ES_LATCH]),
		.src_read(rd_fire && rd_idx == IDX_EV1_SRC),
		.src_q(ev1_src),
		.hit(ev1_hit)
	);

	// New event wins over a same-cycle source read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			event1_pin_q <= 1'b0;
		else if (ev1_hit)
			event1_pin_q <= 1'b1;
		else if (rd_fire && rd_idx == IDX_EV1_SRC)
			event1_pin_q <= 1'b0;
		else if (!ev1_setup_q[ES_LATCH])
			event1_pin_q <= ev1_src[6];
	end

	// Only this flag moves; power and rate settings stay untouched
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wake_normal_q <= 1'b0;
		else if (wake_ctrl_q[1:0] != WAKE_ON)
			wake_normal_q <= 1'b0;
		else if (ev1_hit)
			wake_normal_q <= 1'b1;
	end

	// Protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{awprot, arprot, WAKE_OFF};

endmodule : accel_regs

// ===== accel_regs_sva.sv
// Bus and control output checks for the accel register bank
`timescale 1ns/1ps
module accel_regs_sva
	import accel_regs_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	// Core side
	input wire logic sample_strobe,
	input wire logic [1:0] range_select,
	input wire logic check_drive_enable,
	input wire logic wire_mode_select,
	input wire logic event1_pin
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence src_read;
		arvalid && arready && araddr == {IDX_EV1_SRC, 2'b00};
	endsequence
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	write_answer_a: assert property (wr_taken |=> !bvalid ##1 bvalid)
		else $error("write response late or early");
	read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer missing");
	write_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	read_block_a: assert property (rvalid |-> !arready)
		else $error("read accepted while data pending");
	unmapped_read_a: assert property (arvalid && arready && araddr == 8'hFC
		|=> rresp == RESP_SLVERR && rdata == '0)
		else $error("unmapped read not refused");
	rdata_upper_a: assert property (rvalid |-> rdata[DATA_W-1:8] == '0)
		else $error("upper read bits not zero");
	reset_values_a: assert property (disable iff (1'b0) !aresetn |=>
		range_select == 2'h0 && !check_drive_enable && !wire_mode_select)
		else $error("controls not cleared by reset");
	event_clear_a: assert property (src_read ##0 !sample_strobe
		&& !$past(sample_strobe) |=> !event1_pin)
		else $error("event pin not cleared by source read");
endmodule : accel_regs_sva

// ===== sample_source.sv
// Sensor core stand-in that hands samples to the bank
`timescale 1ns/1ps
module sample_source
	import accel_regs_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Bench request
	input wire logic fire,
	input wire sample_s next_smp,
	// Toward the bank
	output logic sample_strobe,
	output sample_s sample_raw
);
	// Scrambled between strobes so stale data is never trusted
	always_ff @(posedge aclk)
	begin
		sample_strobe <= fire;
		sample_raw <= fire ? next_smp : ~sample_raw;
	end
endmodule : sample_source

// ===== test_accel_output_and_int1_config_regs.sv
// Self-checking bench for the accel register bank
`timescale 1ns/1ps
module test_accel_output_and_int1_config_regs;
	import accel_regs_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, fire = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, strobe;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, range_select;
	logic check_polarity, check_drive_enable, wire_mode_select;
	logic wake_normal, event1_pin;
	sample_s next_smp = '0, raw;
	int miscompares = 0, checks = 0;
	logic [5:0] rst_idx [5] = '{IDX_OUT_CTRL, IDX_WAKE_CTRL, IDX_FILT_REF,
		IDX_STATUS, IDX_EV1_CFG};
	logic [7:0] oc_val [4] = '{8'h14, 8'h3A, 8'hC1, 8'h00};
	logic [5:0] dat_idx [6] = '{IDX_X_LOW, IDX_X_HIGH, IDX_Y_LOW,
		IDX_Y_HIGH, IDX_Z_LOW, IDX_Z_HIGH};
	logic [7:0] dat_exp [6] = '{8'h34, 8'h12, 8'hDC, 8'hFE, 8'h01, 8'h80};
	always #10 aclk = ~aclk;
	sample_source u_src (.aclk(aclk), .fire(fire), .next_smp(next_smp),
		.sample_strobe(strobe), .sample_raw(raw));
	accel_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .sample_strobe(strobe),
		.sample_raw(raw), .range_select(range_select),
		.check_polarity(check_polarity),
		.check_drive_enable(check_drive_enable),
		.wire_mode_select(wire_mode_select), .wake_normal(wake_normal),
		.event1_pin(event1_pin));
	task summarize;
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task chk_rsp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask : chk_rsp
	task hang;
		miscompares++;
		$display("MISMATCH %0t no bus answer", $time);
		summarize();
	endtask : hang
	task wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		if (n == 50)
			hang();
		chk_rsp(bresp, er);
	endtask : wr
	task rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n;
		@(posedge aclk);
		arvalid <= 1'b1;
		rready <= 1'b1;
		araddr <= {idx, 2'b00};
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		if (n == 50)
			hang();
		chk(rdata, {24'h0, e});
		chk_rsp(rresp, er);
	endtask : rd
	task smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge aclk);
		fire <= 1'b1;
		next_smp <= {z, y, x};
		@(posedge aclk);
		fire <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : smp
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rst_idx[i])
			rd(rst_idx[i], REG_RESET, RESP_OKAY);
		foreach (oc_val[i])
		begin
			wr(IDX_OUT_CTRL, oc_val[i], RESP_OKAY);
			rd(IDX_OUT_CTRL, oc_val[i] & OC_WMASK, RESP_OKAY);
			chk({26'h0, range_select, check_polarity, 1'b0, check_drive_enable,
				wire_mode_select}, {26'h0, oc_val[i][5:3], 1'b0,
				oc_val[i][1:0]});
		end
		// Wake and event 1, latched, threshold 0x10
		wr(IDX_WAKE_CTRL, 8'hFF, RESP_OKAY);
		rd(IDX_WAKE_CTRL, {6'h0, WAKE_ON}, RESP_OKAY);
		wr(IDX_EV1_SETUP, 8'h90, RESP_OKAY);
		wr(IDX_EV1_CFG, 8'h02, RESP_OKAY);
		smp(16'h2000, 16'h0000, 16'h0000);
		chk({30'h0, wake_normal, event1_pin}, 32'h3);
		rd(IDX_EV1_SRC, 8'h42, RESP_OKAY);
		chk({31'h0, event1_pin}, 32'h0);
		wr(IDX_EV1_CFG, 8'h8A, RESP_OKAY);
		smp(16'h2000, 16'h0000, 16'h0000);
		chk({31'h0, event1_pin}, 32'h0);
		smp(16'h2000, 16'h2000, 16'h0000);
		chk({31'h0, event1_pin}, 32'h1);
		rd(IDX_EV1_SRC, 8'h4A, RESP_OKAY);
		// Six-direction movement fires only on a pattern change; six-direction position fires on any match
		wr(IDX_EV1_CFG, 8'h42, RESP_OKAY);
		smp(16'h2000, 16'h0000, 16'h0000);
		rd(IDX_EV1_SRC, 8'h42, RESP_OKAY);
		smp(16'h2000, 16'h0000, 16'h0000);
		chk({31'h0, event1_pin}, 32'h0);
		wr(IDX_EV1_CFG, 8'hC2, RESP_OKAY);
		smp(16'h2000, 16'h0000, 16'h0000);
		chk({31'h0, event1_pin}, 32'h1);
		rd(IDX_EV1_SRC, 8'h42, RESP_OKAY);
		wr(IDX_EV1_CFG, 8'h00, RESP_OKAY);
		wr(IDX_WAKE_CTRL, 8'h00, RESP_OKAY);
		// Wake flag falls one edge after the write lands
		@(posedge aclk);
		chk({31'h0, wake_normal}, 32'h0);
		// Data layout, status flags and byte order
		smp(16'h1234, 16'hFEDC, 16'h8001);
		rd(IDX_STATUS, 8'hFF, RESP_OKAY);
		foreach (dat_idx[i])
			rd(dat_idx[i], dat_exp[i], RESP_OKAY);
		rd(IDX_STATUS, 8'h00, RESP_OKAY);
		smp(16'h1234, 16'hFEDC, 16'h8001);
		rd(IDX_STATUS, 8'h0F, RESP_OKAY);
		wr(IDX_OUT_CTRL, 8'h40, RESP_OKAY);
		foreach (dat_idx[i])
			rd(dat_idx[i], dat_exp[i ^ 1], RESP_OKAY);
		// Update lock holds a pair until both bytes are read
		wr(IDX_OUT_CTRL, 8'h80, RESP_OKAY);
		smp(16'h1111, 16'h0000, 16'h0000);
		rd(IDX_X_LOW, 8'h11, RESP_OKAY);
		smp(16'h2222, 16'h0000, 16'h0000);
		rd(IDX_X_HIGH, 8'h11, RESP_OKAY);
		rd(IDX_X_LOW, 8'h22, RESP_OKAY);
		rd(IDX_X_HIGH, 8'h22, RESP_OKAY);
		wr(IDX_OUT_CTRL, 8'h00, RESP_OKAY);
		// Refused and read-only accesses
		rd(6'h3F, 8'h00, RESP_SLVERR);
		wr(6'h3F, 8'h55, RESP_SLVERR);
		wr(IDX_STATUS, 8'h00, RESP_SLVERR);
		rd(IDX_STATUS, 8'hE6, RESP_OKAY);
		// Filter reference mode, then zeroing read
		wr(IDX_FILT_REF, 8'h10, RESP_OKAY);
		rd(IDX_FILT_REF, 8'h10, RESP_OKAY);
		wr(IDX_FILT_CTRL, 8'h28, RESP_OKAY);
		smp(16'h1500, 16'h1000, 16'h0F00);
		rd(IDX_X_HIGH, 8'h05, RESP_OKAY);
		rd(IDX_Z_HIGH, 8'hFF, RESP_OKAY);
		wr(IDX_FILT_CTRL, 8'h08, RESP_OKAY);
		smp(16'h1500, 16'h1000, 16'h0F00);
		rd(IDX_FILT_ZERO, 8'h00, RESP_OKAY);
		smp(16'h1500, 16'h1000, 16'h0F00);
		rd(IDX_X_HIGH, 8'h00, RESP_OKAY);
		rd(IDX_Z_LOW, 8'h00, RESP_OKAY);
		summarize();
	end
endmodule : test_accel_output_and_int1_config_regs

bind accel_regs accel_regs_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
	.sample_strobe(sample_strobe), .range_select(range_select),
	.check_drive_enable(check_drive_enable),
	.wire_mode_select(wire_mode_select), .event1_pin(event1_pin));
